// [rtl/msm_pkg.sv]
// Shared constants and types for the monitor sequencer and fan control
package msm_pkg;

   // ***********************************
   // Clock and timing
   // ***********************************
   localparam int CLK_KHZ        = 100_000;
   localparam int IDLE_MS        = 1000;
   localparam int IDLE_CYC       = IDLE_MS * CLK_KHZ;
   localparam int PERIOD_TYP_MS  = 1200;
   localparam int PERIOD_MAX_MS  = 1400;
   localparam int PERIOD_MAX_CYC = PERIOD_MAX_MS * CLK_KHZ;
   localparam int RAMP_MS        = 10;
   localparam int RAMP_CYC       = RAMP_MS * CLK_KHZ;

   // ***********************************
   // Channel counts and widths
   // ***********************************
   localparam int NVOLT = 5;
   localparam int NTEMP = 3;
   localparam int NCH   = NVOLT + NTEMP;
   localparam int NFAN  = 3;
   localparam int NTACH = 4;
   localparam int DW    = 8;
   localparam int TW    = 16;
   localparam int CW    = 32;

   // Start cycle plus wait per channel keeps the pass inside the worst-case period
   localparam int CONV_MAX_CYC = (PERIOD_MAX_CYC - IDLE_CYC) / NCH - 1;

   localparam logic [2:0] CH_FIRST    = 3'h0;
   localparam logic [2:0] CH_TEMP_INT = 3'h5;
   localparam logic [2:0] CH_REMOTE1  = 3'h6;
   localparam logic [2:0] CH_REMOTE2  = 3'h7;
   localparam logic [2:0] CH_LAST     = 3'h7;

   localparam logic [DW-1:0] DUTY_OFF  = 8'h00;
   localparam logic [DW-1:0] DUTY_FULL = 8'hff;
   localparam logic [DW-1:0] DUTY_STEP = 8'h01;
   localparam logic [3:0]    SHIFT_TOP = 4'h8;

   typedef enum logic [3:0]
   {
      MSM_IDLE  = 4'h1,
      MSM_START = 4'h2,
      MSM_WAIT  = 4'h4,
      MSM_PAUSE = 4'h8
   } msm_state_e;

endpackage

// [rtl/msm_fan_if.sv]
// Interface between the sequencer top and one fan duty channel
`timescale 1ns/1ns
interface msm_fan_if;
   import msm_pkg::*;
   logic                  ramp_tick;
   logic                  run;
   logic                  auto_mode;
   logic [NTEMP-1:0]      zone_mask;
   logic [NTEMP*DW-1:0]   zone_temp;
   logic [DW-1:0]         zone_lo;
   logic [2:0]            range_log;
   logic [DW-1:0]         host_duty;
   logic [DW-1:0]         duty;

   modport ctl
   (
      output ramp_tick, run, auto_mode, zone_mask, zone_temp, zone_lo, range_log, host_duty,
      input  duty
   );
   modport fan
   (
      input  ramp_tick, run, auto_mode, zone_mask, zone_temp, zone_lo, range_log, host_duty,
      output duty
   );
endinterface

// [rtl/msm_fan_ch.sv]
// One fan duty channel: zone selection, automatic target and ramp limiting
`timescale 1ns/1ns
module msm_fan_ch
   import msm_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   msm_fan_if.fan   fan
);

   logic [DW-1:0]   zt [NTEMP];
   logic [DW-1:0]   hot_a;
   logic [DW-1:0]   hot;
   logic [DW:0]     diff;
   logic [3:0]      shamt;
   logic [2*DW-1:0] wide;
   logic [DW-1:0]   target;
   logic [DW-1:0]   want;
   logic [DW-1:0]   duty;
   logic [DW-1:0]   next_duty;

   // ***********************************
   // Hottest of the assigned zones
   // ***********************************
   genvar z;
   generate
      for (z = 0; z < NTEMP; z++)
      begin : g_zone
         assign zt[z] = fan.zone_mask[z] ? fan.zone_temp[z*DW +: DW] : DUTY_OFF;
      end
   endgenerate

   assign hot_a  = (zt[0] > zt[1]) ? zt[0] : zt[1];
   assign hot    = (hot_a > zt[2]) ? hot_a : zt[2];
   // Linear between low limit and low limit plus range, range a power of two
   assign diff   = {1'b0, hot} - {1'b0, fan.zone_lo};
   assign shamt  = SHIFT_TOP - {1'b0, fan.range_log};
   assign wide   = {{DW{1'b0}}, diff[DW-1:0]} << shamt;
   assign target = (hot <= fan.zone_lo) ? DUTY_OFF :
                   (wide > {{DW{1'b0}}, DUTY_FULL}) ? DUTY_FULL : wide[DW-1:0];
   assign want   = fan.auto_mode ? target : fan.host_duty;

   // ***********************************
   // Ramp limiter, one step per tick
   // ***********************************
   assign next_duty = !(fan.run && fan.ramp_tick) ? duty :
                      (duty < want) ? duty + DUTY_STEP :
                      (duty > want) ? duty - DUTY_STEP : duty;

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
         duty <= DUTY_OFF;
      else
         duty <= next_duty;
   end

   assign fan.duty = duty;

   property p_ramp_hold;
      @(posedge i_clock) disable iff (!i_rst_n)
      !fan.ramp_tick |=> $stable(duty);
   endproperty
   a_ramp_hold: assert property (p_ramp_hold) else $error("duty moved off tick");

   property p_ramp_step;
      @(posedge i_clock) disable iff (!i_rst_n)
      fan.ramp_tick |=> (duty == $past(duty) + DUTY_STEP) || (duty == $past(duty) - DUTY_STEP)
                        || (duty == $past(duty));
   endproperty
   a_ramp_step: assert property (p_ramp_step) else $error("duty step larger than one");

   property p_auto_up;
      @(posedge i_clock) disable iff (!i_rst_n)
      fan.run && fan.ramp_tick && fan.auto_mode && (duty < target)
         |=> duty == $past(duty) + DUTY_STEP;
   endproperty
   a_auto_up: assert property (p_auto_up) else $error("auto duty not following zone");

endmodule

// [rtl/msm_top.sv]
// Monitor sequencer, limit checks, fan channels and power modes
`timescale 1ns/1ns
module msm_top
   import msm_pkg::*;
#(
   parameter int P_IDLE_CYC     = IDLE_CYC,
   parameter int P_CONV_MAX_CYC = CONV_MAX_CYC,
   parameter int P_RAMP_CYC     = RAMP_CYC
)
(
   input  wire logic                  i_clock,
   input  wire logic                  i_nrst,
   input  wire logic                  i_mon_enable,
   input  wire logic                  i_cycle_mode,
   input  wire logic                  i_sleep,
   input  wire logic                  i_shutdown,
   output logic                       o_bias_en,
   output logic                       o_osc_en,
   output logic                       o_adc_start,
   output logic [2:0]                 o_adc_chan,
   input  wire logic                  i_adc_done,
   input  wire logic [DW-1:0]         i_adc_data,
   input  wire logic [NCH*DW-1:0]     i_lim_lo,
   input  wire logic [NCH*DW-1:0]     i_lim_hi,
   output logic [NCH*DW-1:0]          o_reading,
   output logic [NCH-1:0]             o_out_of_limit,
   output logic                       o_int_n,
   input  wire logic [NTACH*TW-1:0]   i_tach_count,
   input  wire logic [NTACH*TW-1:0]   i_tach_limit,
   output logic [NTACH-1:0]           o_fan_stall,
   input  wire logic [NFAN-1:0]       i_fan_auto,
   input  wire logic [NFAN*NTEMP-1:0] i_fan_zones,
   input  wire logic [NTEMP*DW-1:0]   i_zone_lo,
   input  wire logic [NTEMP*3-1:0]    i_zone_range,
   input  wire logic [NFAN*DW-1:0]    i_host_duty,
   output logic [NFAN*DW-1:0]         o_fan_duty,
   input  wire logic                  i_acc_req,
   input  wire logic                  i_acc_designated,
   output logic                       o_acc_ok
);

   // ***********************************
   // Reset release
   // ***********************************
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ***********************************
   // Power modes and access gating
   // ***********************************
   wire osc_on = !i_shutdown;
   wire run    = i_mon_enable && !i_sleep && !i_shutdown;

   assign o_osc_en  = osc_on;
   assign o_bias_en = osc_on;
   // Sleep leaves the bus fully usable, shutdown only the designated register
   assign o_acc_ok  = i_acc_req && (!i_shutdown || i_acc_designated);

   // ***********************************
   // Conversion sequencer
   // ***********************************
   msm_state_e      state;
   msm_state_e      next_state;
   logic [2:0]      chan;
   logic [CW-1:0]   timer;
   logic [CW-1:0]   pass_starts;
   logic [DW-1:0]   reading [NCH];
   logic [NCH-1:0]  oor;
   logic            int_n;
   wire conv_end  = (state == MSM_WAIT) &&
                    (i_adc_done || (timer == CW'(P_CONV_MAX_CYC - 1)));
   wire last_chan = (chan == CH_LAST);
   wire idle_end  = (state == MSM_PAUSE) && (timer == CW'(P_IDLE_CYC - 1));

   always_comb
   begin
      next_state = state;
      case (state)
         MSM_IDLE:  next_state = MSM_START;
         MSM_START: next_state = MSM_WAIT;
         MSM_WAIT:
            if (conv_end)
            begin
               if (last_chan && i_cycle_mode)
                  next_state = MSM_PAUSE;
               else
                  next_state = MSM_START;
            end
         MSM_PAUSE:
            if (idle_end)
               next_state = MSM_START;
         default:   next_state = MSM_IDLE;
      endcase
   end

   // Halted modes freeze the sequencer in place rather than resetting
   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
         state <= MSM_IDLE;
      else if (run)
         state <= next_state;
   end

   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
         chan <= CH_FIRST;
      else if (run && conv_end)
         chan <= last_chan ? CH_FIRST : chan + 3'h1;
   end

   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
         timer <= '0;
      else if (run)
         timer <= (state == next_state) ? timer + CW'(1) : '0;
   end

   assign o_adc_start = run && (state == MSM_START);
   assign o_adc_chan  = chan;

   // ***********************************
   // Results and limit checks
   // ***********************************
   genvar c;
   generate
      for (c = 0; c < NCH; c++)
      begin : g_chan
         wire take = run && (state == MSM_WAIT) && i_adc_done && (chan == 3'(c));
         always_ff @(posedge i_clock or negedge rst_n)
         begin
            if (!rst_n)
            begin
               reading[c] <= '0;
               oor[c]     <= 1'b0;
            end
            else if (take)
            begin
               reading[c] <= i_adc_data;
               oor[c]     <= (i_adc_data < i_lim_lo[c*DW +: DW]) ||
                             (i_adc_data > i_lim_hi[c*DW +: DW]);
            end
         end
         assign o_reading[c*DW +: DW] = reading[c];
      end
   endgenerate

   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
         int_n <= 1'b1;
      else
         int_n <= ~|oor;
   end

   assign o_int_n        = int_n;
   assign o_out_of_limit = oor;

   // ***********************************
   // Fan tachometer checks
   // ***********************************
   logic [NTACH-1:0] stall;
   genvar t;
   generate
      for (t = 0; t < NTACH; t++)
      begin : g_tach
         always_ff @(posedge i_clock or negedge rst_n)
         begin
            if (!rst_n)
               stall[t] <= 1'b0;
            else if (osc_on)
               stall[t] <= i_tach_count[t*TW +: TW] > i_tach_limit[t*TW +: TW];
         end
      end
   endgenerate

   assign o_fan_stall = stall;

   // ***********************************
   // Ramp divider and fan channels
   // ***********************************
   logic [CW-1:0]     ramp_cnt;
   logic              ramp_tick;
   logic [NTEMP*DW-1:0] zone_temp;
   // Slow tick keeps fan noise down; stops with the oscillator
   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
         ramp_cnt <= '0;
      else if (osc_on)
         ramp_cnt <= (ramp_cnt == CW'(P_RAMP_CYC - 1)) ? '0 : ramp_cnt + CW'(1);
   end

   assign ramp_tick = osc_on && (ramp_cnt == CW'(P_RAMP_CYC - 1));
   // Zone 0 ambient, zones 1 and 2 remote diodes
   assign zone_temp = {reading[CH_REMOTE2], reading[CH_REMOTE1], reading[CH_TEMP_INT]};

   msm_fan_if fif [NFAN] ();
   genvar f;
   generate
      for (f = 0; f < NFAN; f++)
      begin : g_fan
         assign fif[f].ramp_tick = ramp_tick;
         assign fif[f].run       = osc_on;
         assign fif[f].auto_mode = i_fan_auto[f];
         assign fif[f].zone_mask = i_fan_zones[f*NTEMP +: NTEMP];
         assign fif[f].zone_temp = zone_temp;
         assign fif[f].zone_lo   = i_zone_lo[f*DW +: DW];
         assign fif[f].range_log = i_zone_range[f*3 +: 3];
         assign fif[f].host_duty = i_host_duty[f*DW +: DW];
         assign o_fan_duty[f*DW +: DW] = fif[f].duty;

         msm_fan_ch u_fan
         (
            .i_clock (i_clock),
            .i_rst_n (rst_n),
            .fan     (fif[f])
         );
      end
   endgenerate

   // ***********************************
   // Checks
   // ***********************************
   logic [CW-1:0] pause_len;
   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
         pass_starts <= '0;
      else if (run && (state == MSM_PAUSE))
         pass_starts <= '0;
      else if (o_adc_start)
         pass_starts <= pass_starts + CW'(1);
   end

   always_ff @(posedge i_clock or negedge rst_n)
   begin
      if (!rst_n)
         pause_len <= '0;
      else if (run)
         pause_len <= (state == MSM_PAUSE) ? pause_len + CW'(1) : '0;
   end

   property p_back_to_back;
      @(posedge i_clock) disable iff (!rst_n)
      run && !i_cycle_mode && conv_end && last_chan ##1 run |-> o_adc_start && (chan == CH_FIRST);
   endproperty
   a_back_to_back: assert property (p_back_to_back) else $error("gap in continuous mode");

   property p_cycle_pause;
      @(posedge i_clock) disable iff (!rst_n)
      run && i_cycle_mode && conv_end && last_chan |=> state == MSM_PAUSE;
   endproperty
   a_cycle_pause: assert property (p_cycle_pause) else $error("no idle after pass");

   property p_pause_len;
      @(posedge i_clock) disable iff (!rst_n)
      (state == MSM_PAUSE) && (next_state == MSM_START) |-> pause_len == CW'(P_IDLE_CYC - 1);
   endproperty
   a_pause_len: assert property (p_pause_len) else $error("idle time wrong");

   property p_conv_bound;
      @(posedge i_clock) disable iff (!rst_n)
      state == MSM_WAIT |-> timer < CW'(P_CONV_MAX_CYC);
   endproperty
   a_conv_bound: assert property (p_conv_bound) else $error("conversion overran budget");

   property p_once_per_pass;
      @(posedge i_clock) disable iff (!rst_n)
      run && i_cycle_mode && conv_end && last_chan |=> pass_starts == CW'(NCH);
   endproperty
   a_once_per_pass: assert property (p_once_per_pass) else $error("pass count wrong");

   property p_sleep_hold;
      @(posedge i_clock) disable iff (!rst_n)
      i_sleep ##1 i_sleep |-> $stable(o_reading) && $stable(state) && !o_adc_start && o_osc_en;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("sleep changed state");

   property p_shutdown_off;
      @(posedge i_clock) disable iff (!rst_n)
      i_shutdown |-> !o_osc_en && !o_bias_en && !o_adc_start;
   endproperty
   a_shutdown_off: assert property (p_shutdown_off) else $error("shutdown left power on");

   property p_access;
      @(posedge i_clock) disable iff (!rst_n)
      i_acc_req |-> o_acc_ok == (!i_shutdown || i_acc_designated);
   endproperty
   a_access: assert property (p_access) else $error("access gating wrong");

   property p_int;
      @(posedge i_clock) disable iff (!rst_n)
      |oor |=> !o_int_n;
   endproperty
   a_int: assert property (p_int) else $error("interrupt not raised");

   property p_stall;
      @(posedge i_clock) disable iff (!rst_n)
      !i_shutdown && (i_tach_count[TW-1:0] > i_tach_limit[TW-1:0]) |=> o_fan_stall[0];
   endproperty
   a_stall: assert property (p_stall) else $error("stall not flagged");

endmodule

// [test/msm_adc_model.sv]
// Converter model that answers each start after a short or long delay
`timescale 1ns/1ns
module msm_adc_model
   import msm_pkg::*;
(
   input  wire logic              i_clock,
   input  wire logic              i_start,
   input  wire logic [2:0]        i_chan,
   input  wire logic [NCH*DW-1:0] i_values,
   input  wire logic              i_slow,
   output logic                   o_done,
   output logic [DW-1:0]          o_data
);
   // ***********************************
   // Conversion timing
   // ***********************************
   logic [2:0] chan = 3'h0;
   logic [3:0] left = 4'h0;
   initial o_done = 1'b0;
   initial o_data = 8'h00;

   always @(posedge i_clock)
   begin
      o_done <= 1'b0;
      // Data toggles between answers so a stale value never looks valid
      o_data <= ~o_data;
      if (i_start)
      begin
         chan <= i_chan;
         left <= i_slow ? 4'h7 : 4'h1;
      end
      else if (left == 4'h1)
      begin
         left <= 4'h0;
         o_done <= 1'b1;
         o_data <= i_values[chan*DW+:DW];
      end
      else if (left != 4'h0)
         left <= left - 4'h1;
   end
endmodule

// [test/msm_top_bench.sv]
// Self-checking bench for the monitor sequencer top
`timescale 1ns/1ns
module msm_top_bench;
   import msm_pkg::*;
   localparam int IDLE = 20;
   localparam int CONV = 50;
   localparam int RAMP = 4;
   typedef struct {logic [2:0] chan; int gmin; int gmax;} msm_exp_s;
   // ***********************************
   // Signals
   // ***********************************
   logic                  i_clock = 1'b0;
   logic                  i_nrst = 1'b0;
   logic                  i_mon_enable = 1'b0;
   logic                  i_cycle_mode = 1'b0;
   logic                  i_sleep = 1'b0;
   logic                  i_shutdown = 1'b0;
   logic                  i_acc_req = 1'b0;
   logic                  i_acc_designated = 1'b0;
   logic                  slow = 1'b0;
   logic [NCH*DW-1:0]     i_lim_lo = 64'h0;
   logic [NCH*DW-1:0]     i_lim_hi = 64'h0;
   logic [NCH*DW-1:0]     vals = 64'h0;
   logic [NTACH*TW-1:0]   i_tach_count = 64'h0;
   logic [NTACH*TW-1:0]   i_tach_limit = 64'h0;
   logic [NFAN-1:0]       i_fan_auto = 3'h6;
   logic [NFAN*NTEMP-1:0] i_fan_zones = 9'h077;
   logic [NTEMP*DW-1:0]   i_zone_lo = 24'h282000;
   logic [NTEMP*3-1:0]    i_zone_range = 9'h1e0;
   logic [NFAN*DW-1:0]    i_host_duty = 24'h000005;
   logic                  o_bias_en, o_osc_en, o_adc_start, i_adc_done, o_int_n, o_acc_ok;
   logic [2:0]            o_adc_chan;
   logic [DW-1:0]         i_adc_data;
   logic [NCH*DW-1:0]     o_reading;
   logic [NCH-1:0]        o_out_of_limit;
   logic [NTACH-1:0]      o_fan_stall;
   logic [NFAN*DW-1:0]    o_fan_duty;
   logic [NFAN*DW-1:0]    prev_duty = 24'h0;
   int                    cyc = 0;
   int                    last_done = 0;
   int                    chg[NFAN] = '{0, 0, 0};
   int                    mismatches = 0;
   int                    total_checks = 0;
   int                    seed = 32'hd88eff78;
   msm_exp_s              exp_q[$];

   always #5 i_clock = ~i_clock;

   msm_top #(.P_IDLE_CYC(IDLE), .P_CONV_MAX_CYC(CONV), .P_RAMP_CYC(RAMP)) msm_top_i
   (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_mon_enable(i_mon_enable),
      .i_cycle_mode(i_cycle_mode), .i_sleep(i_sleep), .i_shutdown(i_shutdown),
      .o_bias_en(o_bias_en), .o_osc_en(o_osc_en), .o_adc_start(o_adc_start),
      .o_adc_chan(o_adc_chan), .i_adc_done(i_adc_done), .i_adc_data(i_adc_data),
      .i_lim_lo(i_lim_lo), .i_lim_hi(i_lim_hi), .o_reading(o_reading),
      .o_out_of_limit(o_out_of_limit), .o_int_n(o_int_n), .i_tach_count(i_tach_count),
      .i_tach_limit(i_tach_limit), .o_fan_stall(o_fan_stall), .i_fan_auto(i_fan_auto),
      .i_fan_zones(i_fan_zones), .i_zone_lo(i_zone_lo), .i_zone_range(i_zone_range),
      .i_host_duty(i_host_duty), .o_fan_duty(o_fan_duty), .i_acc_req(i_acc_req),
      .i_acc_designated(i_acc_designated), .o_acc_ok(o_acc_ok)
   );

   msm_adc_model msm_adc_model_i
   (
      .i_clock(i_clock), .i_start(o_adc_start), .i_chan(o_adc_chan), .i_values(vals),
      .i_slow(slow), .o_done(i_adc_done), .o_data(i_adc_data)
   );
   // ***********************************
   // Checking
   // ***********************************
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic note(input bit bad, input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (bad)
      begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      note(got !== exp, {63'h0, got}, {63'h0, exp});
   endtask

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      note(got !== exp, {56'h0, got}, {56'h0, exp});
   endtask

   task automatic check_vec(input logic [63:0] got, input logic [63:0] exp);
      note(got !== exp, got, exp);
   endtask

   task automatic check_gap(input int got, input int lo, input int hi);
      note(got < lo || got > hi, 64'(got), 64'(lo));
   endtask

   function automatic logic [7:0] flags(input logic [63:0] v, input logic [7:0] lo, hi);
      logic [7:0] f;
      for (int c = 0; c < NCH; c++)
         f[c] = (v[c*DW+:DW] < lo) || (v[c*DW+:DW] > hi);
      return f;
   endfunction

   always @(posedge i_clock)
   begin
      cyc = cyc + 1;
      if (cyc == 5000)
      begin
         mismatches++;
         results();
      end
   end

   // Read at the falling edge, before the drivers' updates of that edge land
   always @(negedge i_clock)
   begin
      msm_exp_s   e;
      logic [7:0] d, p;
      if (i_adc_done === 1'b1)
         last_done = cyc;
      if (i_sleep | i_shutdown)
         check_bit(o_adc_start, 1'b0);
      else if (o_adc_start === 1'b1 && exp_q.size() > 0)
      begin
         e = exp_q.pop_front();
         check_byte({5'h0, o_adc_chan}, {5'h0, e.chan});
         if (e.gmax > 0)
            check_gap(cyc - last_done, e.gmin, e.gmax);
      end
      for (int f = 0; f < NFAN; f++)
      begin
         d = o_fan_duty[f*DW+:DW];
         p = prev_duty[f*DW+:DW];
         if (i_nrst === 1'b1 && d !== p)
         begin
            check_bit((d - p == 8'h01) || (p - d == 8'h01), 1'b1);
            check_gap(cyc - chg[f], RAMP, 32'h7fffffff);
            chg[f] = cyc;
         end
      end
      prev_duty = o_fan_duty;
   end
   // ***********************************
   // Stimulus
   // ***********************************
   task automatic start_run(input logic cm, input logic sl, input logic [7:0] lo, hi);
      i_nrst <= 1'b0;
      i_mon_enable <= 1'b0;
      i_cycle_mode <= cm;
      slow <= sl;
      i_lim_lo <= {NCH{lo}};
      i_lim_hi <= {NCH{hi}};
      vals = {$random(seed), $random(seed)};
      // Keep voltages off the limit values, where the compare sense is open
      for (int c = 0; c < NVOLT; c++)
         if (vals[c*DW+:DW] == lo || vals[c*DW+:DW] == hi)
            vals[c*DW+:DW] = vals[c*DW+:DW] ^ 8'h01;
      vals[63:40] = 24'h252230;
      repeat (16) @(negedge i_clock);
      i_nrst <= 1'b1;
      repeat (4) @(negedge i_clock);
   endtask

   task automatic push_seq(input int from, input int n, input int wmin, input int wmax);
      msm_exp_s e;
      for (int i = 0; i < n; i++)
      begin
         e.chan = 3'((from + i) % NCH);
         e.gmin = (e.chan == 3'h0) ? wmin : 1;
         e.gmax = (i == 0) ? 0 : (e.chan == 3'h0) ? wmax : 1;
         exp_q.push_back(e);
      end
   endtask

   task automatic drain;
      while (exp_q.size() > 0)
         @(negedge i_clock);
      repeat (4) @(negedge i_clock);
   endtask

   task automatic access(input logic des, input logic exp);
      i_acc_req <= 1'b1;
      i_acc_designated <= des;
      @(negedge i_clock);
      check_bit(o_acc_ok, exp);
      i_acc_req <= 1'b0;
      @(negedge i_clock);
   endtask

   initial
   begin
      logic [NTACH*TW-1:0] tc, tl;
      logic [3:0]          st;
      logic [NCH*DW-1:0]   old;
      start_run(1'b0, 1'b0, 8'h40, 8'hc0);
      push_seq(0, 9, 1, 1);
      i_mon_enable <= 1'b1;
      drain();
      check_vec(o_reading, vals);
      check_byte(o_out_of_limit, flags(vals, 8'h40, 8'hc0));
      check_bit(o_int_n, ~|flags(vals, 8'h40, 8'hc0));
      repeat (4)
      begin
         tc = {$random(seed), $random(seed)};
         tl = {$random(seed), $random(seed)};
         // Tach 1 sits on its limit, tach 0 always over it
         tc[31:16] = tl[31:16];
         tl[15] = 1'b0;
         tc[15] = 1'b1;
         i_tach_count <= tc;
         i_tach_limit <= tl;
         repeat (2) @(negedge i_clock);
         for (int f = 0; f < NTACH; f++)
            st[f] = tc[f*TW+:TW] > tl[f*TW+:TW];
         check_byte({4'h0, o_fan_stall}, {4'h0, st});
      end
      repeat (500) @(negedge i_clock);
      check_byte(o_fan_duty[7:0], 8'h05);
      check_byte(o_fan_duty[15:8], 8'h50);
      check_byte(o_fan_duty[23:16], 8'h10);
      $display("end of continuous and fan test");
      start_run(1'b1, 1'b0, 8'h00, 8'hff);
      push_seq(0, 17, IDLE, IDLE + 2);
      i_mon_enable <= 1'b1;
      drain();
      check_vec(o_reading, vals);
      check_byte(o_out_of_limit, 8'h00);
      check_bit(o_int_n, 1'b1);
      $display("end of cycle mode test");
      start_run(1'b0, 1'b1, 8'h40, 8'hc0);
      push_seq(0, 12, 1, 1);
      i_mon_enable <= 1'b1;
      while (exp_q.size() > 0)
         @(negedge i_clock);
      // Step past the start pulse so the halt lands inside the slow conversion
      repeat (2) @(negedge i_clock);
      // Halt inside a conversion; its late answer must be dropped
      i_sleep <= 1'b1;
      old = vals;
      vals[3*DW+:DW] = ~vals[3*DW+:DW];
      repeat (20) @(negedge i_clock);
      check_bit(o_bias_en & o_osc_en, 1'b1);
      access(1'b0, 1'b1);
      i_sleep <= 1'b0;
      i_shutdown <= 1'b1;
      repeat (20) @(negedge i_clock);
      check_bit(o_bias_en | o_osc_en, 1'b0);
      access(1'b0, 1'b0);
      access(1'b1, 1'b1);
      check_vec(o_reading, old);
      i_shutdown <= 1'b0;
      push_seq(4, 4, 1, 1);
      drain();
      check_vec(o_reading, old);
      $display("end of power mode test");
      results();
   end
endmodule
